// ---- src/acm_mode_ctrl.sv ----
`timescale 1ns/10ps
// What this block does
// - output counts per g are 256, 128, 64 for 2g, 4g, 8g ranges
// - the clock line is never held low; no clock stretching
// - when powered off nothing runs and the bus gets no response
// - standby keeps digital logic only; sensing and sample clocks stop
// - both supplies up with run-enable clear means standby, bus usable
// - run-enable set enters active, all functions on, bus usable
// - going active to standby keeps all register contents
// - going standby to active clears a defined register subset
// - wake and sleep run only inside active
// - output data from address 0x00 as two's complement, zero mid-range
// - self-test output is acceleration plus test force, range-scaled
// - spikes up to 50 ns on data and clock are rejected
// - first valid sample waits two data periods plus 1 ms
module acm_mode_ctrl #(
  parameter int unsigned        TURNON_CYC = acm_pkg::TON_CYC,
  parameter logic [6:0]         DEV_ADDR   = 7'h2a,
  parameter int unsigned        ODR_DIV    = 16,
  parameter logic signed [11:0] ST_FORCE   = 12'sh040
) (
  // clocks and resets
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_sense_clk,
  input  wire logic                   i_sense_reset_n,
  // supplies and control
  input  wire logic                   i_vdd_ok,
  input  wire logic                   i_vddio_ok,
  input  wire logic                   i_run_en,
  input  wire logic [1:0]             i_fs_range,
  input  wire logic                   i_self_test,
  // sensing element
  input  wire acm_pkg::acm_accel_type i_accel,
  // i2c pins
  input  wire logic                   i_scl,
  input  wire logic                   i_sda_in,
  output logic                        o_sda_out,
  output logic                        o_sda_oe,
  output logic                        o_scl_oe,
  // mode status
  output acm_pkg::acm_mode_type       o_mode,
  output logic                        o_analog_en,
  output logic                        o_digital_en,
  output logic                        o_clk_run,
  output logic                        o_i2c_avail,
  output logic                        o_reg_reset,
  output logic                        o_data_valid,
  output acm_pkg::acm_sample_type     o_sample,
  // register writes
  output logic                        o_wr_valid,
  output acm_pkg::acm_wr_type         o_wr
);
  import acm_pkg::*;

  localparam int TON_W = $clog2(TURNON_CYC + 1);
  localparam int ODR_W = $clog2(ODR_DIV);

  logic [1:0] pin_s1_q, pin_s2_q, pwr_s1_q, pwr_s2_q;
  logic       line_q [2];
  logic       line_d [2];
  logic [3:0] fcnt_q [2];
  logic [3:0] fcnt_d [2];
  logic       prev_q [2];
  logic       scl_rise, scl_fall, start, stop, pwr_ok, enter_act, arrive;
  acm_mode_type   mode_q, mode_d;
  logic [TON_W-1:0] ton_q, ton_d;
  logic [1:0]     scnt_q, scnt_d;
  logic           rst_q, rst_d, valid_q, valid_d;
  acm_sample_type out_q, out_d;
  acm_i2c_type    st_q, st_d;
  logic [3:0]     cnt_q, cnt_d;
  logic [7:0]     sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rd_byte;
  logic           rw_q, rw_d, first_q, first_d, oe_q, oe_d, mack_q, mack_d;
  logic           wrv_q, wrv_d;
  acm_wr_type     wr_q, wr_d;
  logic [OUT_W-1:0] rd_val;
  logic           req_s1_q, req_s2_q, ack_q;
  // sense domain
  logic           sact_s1_q, sact_s2_q, ack_s1_q, ack_s2_q, req_q, req_d, tick;
  logic [2:0]     cfg_s1_q, cfg_s2_q;
  acm_accel_type  acc_s1_q, acc_s2_q;
  logic [ODR_W-1:0] odr_q, odr_d;
  acm_sample_type smp_q, smp_d, scaled;
  logic [1:0]     shift;

  // two-flop synchronisers for pins and supply detectors
  always_ff @(posedge i_ref_clk) begin
    pin_s1_q <= {i_sda_in, i_scl};
    pin_s2_q <= pin_s1_q;
    pwr_s1_q <= {i_vddio_ok, i_vdd_ok};
    pwr_s2_q <= pwr_s1_q;
  end

  // spike filter: a level must differ for FILT_CNT samples to be taken
  for (genvar g = 0; g < 2; g++) begin : g_filt
    always_comb begin
      line_d[g] = line_q[g];
      fcnt_d[g] = 4'h0;
      if (pin_s2_q[g] != line_q[g]) begin
        if (fcnt_q[g] == FILT_CNT - 4'h1) begin
          line_d[g] = pin_s2_q[g];
        end else begin
          fcnt_d[g] = fcnt_q[g] + 4'h1;
        end
      end
    end
    always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
        line_q[g] <= 1'b1;
        fcnt_q[g] <= 4'h0;
        prev_q[g] <= 1'b1;
      end else begin
        line_q[g] <= line_d[g];
        fcnt_q[g] <= fcnt_d[g];
        prev_q[g] <= line_q[g];
      end
    end
  end

  // bus events from filtered lines
  assign scl_rise = line_q[0] & ~prev_q[0];
  assign scl_fall = ~line_q[0] & prev_q[0];
  assign start    = line_q[0] & prev_q[0] & prev_q[1] & ~line_q[1];
  assign stop     = line_q[0] & prev_q[0] & ~prev_q[1] & line_q[1];
  assign pwr_ok   = pwr_s2_q[0] & pwr_s2_q[1];
  assign enter_act = (mode_q == MODE_STBY) && pwr_ok && i_run_en;
  assign arrive   = req_s2_q != ack_q;

  // power state machine and turn-on timing
  always_comb begin
    mode_d  = mode_q;
    ton_d   = ton_q;
    scnt_d  = scnt_q;
    rst_d   = 1'b0;
    valid_d = valid_q;
    case (mode_q)
      MODE_OFF: begin
        valid_d = 1'b0;
        if (pwr_ok) mode_d = MODE_STBY;
      end
      MODE_STBY: begin
        if (!pwr_ok) begin
          mode_d = MODE_OFF;
        end else if (i_run_en) begin
          mode_d  = MODE_ACT;
          rst_d   = 1'b1;
          ton_d   = '0;
          scnt_d  = 2'h0;
          valid_d = 1'b0;
        end
      end
      MODE_ACT: begin
        if (!pwr_ok) begin
          mode_d = MODE_OFF;
        end else if (!i_run_en) begin
          mode_d = MODE_STBY;
        end else if (ton_q != TON_W'(TURNON_CYC)) begin
          ton_d = ton_q + 1'b1;
        end else if (arrive && scnt_q != TON_ODRS) begin
          scnt_d = scnt_q + 2'h1;
        end
        if (mode_d == MODE_ACT) begin
          valid_d = (ton_q == TON_W'(TURNON_CYC)) && (scnt_q == TON_ODRS);
        end
      end
      default: mode_d = MODE_OFF;
    endcase
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      mode_q  <= MODE_OFF;
      ton_q   <= '0;
      scnt_q  <= 2'h0;
      rst_q   <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      ton_q   <= ton_d;
      scnt_q  <= scnt_d;
      rst_q   <= rst_d;
      valid_q <= valid_d;
    end
  end

  // sample capture from the sense domain, kept across standby
  always_comb begin
    out_d = out_q;
    if (mode_q == MODE_OFF || enter_act) begin
      out_d = '0;
    end else if (mode_q == MODE_ACT && arrive) begin
      out_d = smp_q;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      out_q    <= '0;
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      ack_q    <= 1'b0;
    end else begin
      out_q    <= out_d;
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      ack_q    <= req_s2_q;
    end
  end

  // read data map: msb then lsb per axis from DATA_ADDR
  always_comb begin
    case (ptr_q[2:1])
      2'h0:    rd_val = out_q.x;
      2'h1:    rd_val = out_q.y;
      default: rd_val = out_q.z;
    endcase
    if (ptr_q - DATA_ADDR >= DATA_BYTES) begin
      rd_byte = 8'h00;
    end else if (ptr_q[0]) begin
      rd_byte = {rd_val[1:0], 6'h00};
    end else begin
      rd_byte = rd_val[OUT_W-1:2];
    end
  end

  // i2c slave; only pulls data low, never touches the clock line
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; sh_d = sh_q; tx_d = tx_q; ptr_d = ptr_q;
    rw_d = rw_q; first_d = first_q; oe_d = oe_q; mack_d = mack_q;
    wrv_d = 1'b0;
    wr_d  = wr_q;
    if (mode_q == MODE_OFF) begin
      st_d  = I2C_IDLE;
      oe_d  = 1'b0;
      ptr_d = DATA_ADDR;
    end else if (start) begin
      st_d = I2C_ADDR; cnt_d = 4'h0; oe_d = 1'b0; first_d = 1'b1;
    end else if (stop) begin
      st_d = I2C_IDLE; oe_d = 1'b0;
    end else begin
      case (st_q)
        I2C_ADDR, I2C_WRITE: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], line_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == BYTE_BITS) begin
            cnt_d = 4'h0;
            if (st_q == I2C_ADDR) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                rw_d = sh_q[0]; oe_d = 1'b1; st_d = I2C_ACK;
              end else begin
                st_d = I2C_IDLE;
              end
            end else begin
              oe_d = 1'b1; st_d = I2C_ACK; first_d = 1'b0;
              if (first_q) begin
                ptr_d = sh_q;
              end else begin
                wrv_d = 1'b1; wr_d = '{addr: ptr_q, data: sh_q}; ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        I2C_ACK, I2C_MACK: begin
          if (scl_rise && st_q == I2C_MACK) mack_d = ~line_q[1];
          if (scl_fall) begin
            if (st_q == I2C_MACK && !mack_q) begin
              st_d = I2C_IDLE; oe_d = 1'b0;
            end else if (rw_q) begin
              tx_d = rd_byte; oe_d = ~rd_byte[7]; ptr_d = ptr_q + 8'h01; st_d = I2C_READ;
            end else begin
              oe_d = 1'b0; st_d = I2C_WRITE;
            end
          end
        end
        I2C_READ: begin
          if (scl_rise) begin
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (cnt_q == BYTE_BITS) begin
              oe_d = 1'b0; cnt_d = 4'h0; st_d = I2C_MACK;
            end else begin
              tx_d = {tx_q[6:0], 1'b0}; oe_d = ~tx_q[6];
            end
          end
        end
        default: st_d = I2C_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st_q <= I2C_IDLE; cnt_q <= 4'h0; sh_q <= 8'h00; tx_q <= 8'h00;
      ptr_q <= DATA_ADDR; rw_q <= 1'b0; first_q <= 1'b0; oe_q <= 1'b0;
      mack_q <= 1'b0; wrv_q <= 1'b0; wr_q <= '0;
    end else begin
      st_q <= st_d; cnt_q <= cnt_d; sh_q <= sh_d; tx_q <= tx_d;
      ptr_q <= ptr_d; rw_q <= rw_d; first_q <= first_d; oe_q <= oe_d;
      mack_q <= mack_d; wrv_q <= wrv_d; wr_q <= wr_d;
    end
  end

  // outputs
  assign o_sda_out    = 1'b0;
  assign o_sda_oe     = oe_q;
  assign o_scl_oe     = 1'b0;
  assign o_mode       = mode_q;
  assign o_analog_en  = mode_q == MODE_ACT;
  assign o_clk_run    = mode_q == MODE_ACT;
  assign o_digital_en = mode_q != MODE_OFF;
  assign o_i2c_avail  = mode_q != MODE_OFF;
  assign o_reg_reset  = rst_q;
  assign o_data_valid = valid_q;
  assign o_sample     = out_q;
  assign o_wr_valid   = wrv_q;
  assign o_wr         = wr_q;

  // sense domain: range scaling with self-test force and saturation
  always_comb begin
    case (cfg_s2_q[2:1])
      FS_4G:   shift = SH_4G;
      FS_8G:   shift = SH_8G;
      default: shift = SH_2G;
    endcase
  end
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [12:0] sum, shv;
    always_comb begin
      // a size cast of a struct slice would zero-fill, so mark it signed first
      sum = 13'(signed'(acc_s2_q[a*IN_W +: IN_W]))
            + (cfg_s2_q[0] ? 13'(ST_FORCE) : 13'sh0000);
      shv = sum >>> shift;
      if (shv > OUT_MAX) begin
        scaled[a*OUT_W +: OUT_W] = OUT_MAX[OUT_W-1:0];
      end else if (shv < OUT_MIN) begin
        scaled[a*OUT_W +: OUT_W] = OUT_MIN[OUT_W-1:0];
      end else begin
        scaled[a*OUT_W +: OUT_W] = shv[OUT_W-1:0];
      end
    end
  end

  // sense domain: data-rate divider and toggle handshake
  assign tick = sact_s2_q && (odr_q == ODR_W'(ODR_DIV - 1));
  always_comb begin
    odr_d = odr_q;
    req_d = req_q;
    smp_d = smp_q;
    if (!sact_s2_q) begin
      odr_d = '0;
    end else begin
      odr_d = tick ? '0 : odr_q + 1'b1;
    end
    if (tick && ack_s2_q == req_q) begin
      smp_d = scaled;
      req_d = ~req_q;
    end
  end
  always_ff @(posedge i_sense_clk) begin
    if (!i_sense_reset_n) begin
      sact_s1_q <= 1'b0; sact_s2_q <= 1'b0; ack_s1_q <= 1'b0; ack_s2_q <= 1'b0;
      cfg_s1_q <= 3'h0; cfg_s2_q <= 3'h0; acc_s1_q <= '0; acc_s2_q <= '0;
      odr_q <= '0; req_q <= 1'b0; smp_q <= '0;
    end else begin
      sact_s1_q <= mode_q == MODE_ACT;
      sact_s2_q <= sact_s1_q;
      ack_s1_q  <= ack_q;
      ack_s2_q  <= ack_s1_q;
      cfg_s1_q  <= {i_fs_range, i_self_test};
      cfg_s2_q  <= cfg_s1_q;
      acc_s1_q  <= i_accel;
      acc_s2_q  <= acc_s1_q;
      odr_q <= odr_d; req_q <= req_d; smp_q <= smp_d;
    end
  end

  // checks
  a_clk_never_held: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (st_q != I2C_IDLE) |-> !o_scl_oe) else $error("clock line driven");
  a_off_no_answer: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mode_q == MODE_OFF) |=> !o_sda_oe) else $error("answered while off");
  a_stby_digital: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mode_q == MODE_STBY) |-> (!o_analog_en && !o_clk_run && o_digital_en))
    else $error("standby enables wrong");
  a_supply_standby: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mode_q == MODE_OFF && pwr_ok) |=> (mode_q == MODE_STBY && o_i2c_avail))
    else $error("no standby on supply");
  a_run_activates: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    enter_act |=> (mode_q == MODE_ACT && o_reg_reset && o_sample == '0) ##1 !o_reg_reset)
    else $error("bad active entry");
  a_stby_retains: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (mode_q == MODE_STBY && $past(mode_q) == MODE_STBY) |-> $stable(o_sample))
    else $error("data lost in standby");
  a_sleep_in_act: assert property (@(posedge i_sense_clk) disable iff (!i_sense_reset_n)
    !sact_s2_q |=> (odr_q == '0 && $stable(req_q))) else $error("sampling outside active");
  a_scale_count: assert property (@(posedge i_sense_clk) disable iff (!i_sense_reset_n)
    (tick && ack_s2_q == req_q && cfg_s2_q == {FS_2G, 1'b0}
     && acc_s2_q.x <= OUT_MAX && acc_s2_q.x >= OUT_MIN)
    |=> (smp_q.x == $past(acc_s2_q.x[OUT_W-1:0])))
    else $error("scaled sample wrong");
  a_filter_spike: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (line_q[0] != $past(line_q[0])) |-> ($past(fcnt_q[0]) == FILT_CNT - 4'h1))
    else $error("spike passed filter");
  a_turnon_wait: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(o_data_valid) |-> ($past(scnt_q) == TON_ODRS && $past(ton_q) == TON_W'(TURNON_CYC)))
    else $error("valid too early");
  c_active: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) enter_act);
  c_valid: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) $rose(o_data_valid));
  c_addr_ack: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) st_q == I2C_ACK);
  c_read_byte: cover property (@(posedge i_ref_clk) disable iff (!i_reset_n) st_q == I2C_MACK);
endmodule

// ---- src/acm_pkg.sv ----
package acm_pkg;
  // timing base and input spike filter
  localparam int unsigned CLK_NS    = 5;
  localparam int unsigned SPIKE_NS  = 50;
  localparam int unsigned FILT_CYC  = SPIKE_NS / CLK_NS + 1;
  localparam logic [3:0]  FILT_CNT  = 4'(FILT_CYC);
  // turn-on delay after standby to active
  localparam int unsigned TURNON_US = 1000;
  localparam int unsigned TON_CYC   = TURNON_US * 1000 / CLK_NS;
  localparam logic [1:0]  TON_ODRS  = 2'h2;
  // full-scale range codes and sensitivities
  localparam logic [1:0]  FS_2G     = 2'h0;
  localparam logic [1:0]  FS_4G     = 2'h1;
  localparam logic [1:0]  FS_8G     = 2'h2;
  localparam int unsigned CPG_2G    = 256;
  localparam int unsigned CPG_4G    = 128;
  localparam int unsigned CPG_8G    = 64;
  localparam logic [1:0]  SH_2G     = 2'($clog2(CPG_2G / CPG_2G));
  localparam logic [1:0]  SH_4G     = 2'($clog2(CPG_2G / CPG_4G));
  localparam logic [1:0]  SH_8G     = 2'($clog2(CPG_2G / CPG_8G));
  // data widths and limits
  localparam int unsigned IN_W      = 12;
  localparam int unsigned OUT_W     = 10;
  localparam logic signed [12:0] OUT_MAX = 13'sh01ff;
  localparam logic signed [12:0] OUT_MIN = -13'sh0200;
  // i2c framing and output data map
  localparam logic [3:0]  BYTE_BITS  = 4'h8;
  localparam logic [7:0]  DATA_ADDR  = 8'h00;
  localparam logic [7:0]  DATA_BYTES = 8'h06;
  // power states
  typedef enum logic [2:0] {
    MODE_OFF  = 3'b001,
    MODE_STBY = 3'b010,
    MODE_ACT  = 3'b100
  } acm_mode_type;
  // i2c slave states
  typedef enum logic [5:0] {
    I2C_IDLE  = 6'b000001,
    I2C_ADDR  = 6'b000010,
    I2C_ACK   = 6'b000100,
    I2C_WRITE = 6'b001000,
    I2C_READ  = 6'b010000,
    I2C_MACK  = 6'b100000
  } acm_i2c_type;
  // raw acceleration, units of 1/256 g
  typedef struct packed {
    logic signed [IN_W-1:0] x;
    logic signed [IN_W-1:0] y;
    logic signed [IN_W-1:0] z;
  } acm_accel_type;
  // scaled two's-complement sample
  typedef struct packed {
    logic signed [OUT_W-1:0] x;
    logic signed [OUT_W-1:0] y;
    logic signed [OUT_W-1:0] z;
  } acm_sample_type;
  // register write from the bus
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } acm_wr_type;
endpackage

// ---- src/acm_mode_ctrl_note.sv ----
`timescale 1ns/10ps

// ---- verification/acm_i2c_host.sv ----
`timescale 1ns/10ps
// i2c bus master model; open drain, timed off the ref clock
module acm_i2c_host #(
  parameter int QTR = 130 // quarter bit of 650 ns, about 385 kHz
) (
  // timing clock
  input  wire logic i_ref_clk,
  // data line as seen on the bus
  input  wire logic i_sda,
  // pulls, high = line held low
  output logic      o_scl_oe,
  output logic      o_sda_oe
);
  // bus idle: both lines released
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end

  // wait n ref cycles, then step just past the edge
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // start, or repeated start from a low clock phase
  task automatic start();
    o_sda_oe = 1'b0;
    wt(QTR);
    o_scl_oe = 1'b0;
    wt(QTR);
    o_sda_oe = 1'b1;
    wt(QTR);
    o_scl_oe = 1'b1;
    wt(QTR);
  endtask

  // stop from a low clock phase
  task automatic stop();
    o_sda_oe = 1'b1;
    wt(QTR);
    o_scl_oe = 1'b0;
    wt(QTR);
    o_sda_oe = 1'b0;
    wt(QTR);
  endtask

  // one bit; g adds 40 ns spikes on both lines in the high phase
  task automatic bit_xfer(input logic b, input logic g, output logic r);
    o_sda_oe = ~b;
    wt(QTR);
    o_scl_oe = 1'b0;
    wt(QTR);
    r = i_sda;
    if (g) begin
      o_scl_oe = 1'b1;
      wt(8);
      o_scl_oe = 1'b0;
      wt(40);
      o_sda_oe = ~o_sda_oe;
      wt(8);
      o_sda_oe = ~o_sda_oe;
    end
    wt(QTR);
    o_scl_oe = 1'b1;
    wt(QTR);
  endtask

  // byte out, msb first; ack high when the slave pulled data low
  task automatic wbyte(input logic [7:0] d, input logic g, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], g && (i == 4), r);
    end
    bit_xfer(1'b1, 1'b0, r);
    ack = ~r;
  endtask

  // byte in, msb first; last byte is not acknowledged
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, 1'b0, r);
      d[i] = r;
    end
    bit_xfer(last, 1'b0, r);
  endtask
endmodule

// ---- verification/acm_mode_ctrl_tb.sv ----
`timescale 1ns/10ps
// bench for the operating-mode block against an i2c master model
module acm_mode_ctrl_tb;
  import acm_pkg::*;
  localparam int unsigned        TON  = 50;
  localparam logic signed [11:0] STF  = 12'sh040;
  localparam logic [6:0]         DEVA = 7'h2a;
  // stimulus and observed signals
  logic           i_ref_clk       = 1'b0;
  logic           i_sense_clk     = 1'b0;
  logic           i_reset_n       = 1'b0;
  logic           i_sense_reset_n = 1'b0;
  logic           i_vdd_ok        = 1'b0;
  logic           i_vddio_ok      = 1'b0;
  logic           i_run_en        = 1'b0;
  logic [1:0]     i_fs_range      = 2'h0;
  logic           i_self_test     = 1'b0;
  acm_accel_type  i_accel         = '0;
  logic           host_scl_oe;
  logic           host_sda_oe;
  wire            scl;
  wire            sda;
  logic           o_sda_out;
  logic           o_sda_oe;
  logic           o_scl_oe;
  acm_mode_type   o_mode;
  logic           o_analog_en;
  logic           o_digital_en;
  logic           o_clk_run;
  logic           o_i2c_avail;
  logic           o_reg_reset;
  logic           o_data_valid;
  acm_sample_type o_sample;
  logic           o_wr_valid;
  acm_wr_type     o_wr;
  int             miscompares     = 0;
  int             num_checks      = 0;
  int             wr_cnt          = 0;
  acm_wr_type     wr_last         = '0;

  // clocks: ref 5 ns, sense 160 ns with an unrelated phase
  always #2.5 i_ref_clk = ~i_ref_clk;
  initial begin
    #37;
    forever #80 i_sense_clk = ~i_sense_clk;
  end

  // pulled-up open-drain lines
  assign scl = ~(host_scl_oe | o_scl_oe);
  assign sda = ~(host_sda_oe | (o_sda_oe & ~o_sda_out));

  acm_mode_ctrl #(
    .TURNON_CYC(TON), .DEV_ADDR(DEVA), .ODR_DIV(16), .ST_FORCE(STF)
  ) u_acm_mode_ctrl (
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_sense_clk(i_sense_clk),
    .i_sense_reset_n(i_sense_reset_n), .i_vdd_ok(i_vdd_ok), .i_vddio_ok(i_vddio_ok),
    .i_run_en(i_run_en), .i_fs_range(i_fs_range), .i_self_test(i_self_test),
    .i_accel(i_accel), .i_scl(scl), .i_sda_in(sda), .o_sda_out(o_sda_out),
    .o_sda_oe(o_sda_oe), .o_scl_oe(o_scl_oe), .o_mode(o_mode), .o_analog_en(o_analog_en),
    .o_digital_en(o_digital_en), .o_clk_run(o_clk_run), .o_i2c_avail(o_i2c_avail),
    .o_reg_reset(o_reg_reset), .o_data_valid(o_data_valid), .o_sample(o_sample),
    .o_wr_valid(o_wr_valid), .o_wr(o_wr));

  acm_i2c_host u_acm_i2c_host (
    .i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl_oe(host_scl_oe), .o_sda_oe(host_sda_oe));

  // one comparison, counted; ok must be a clean 1
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // forwarded writes are counted; the clock line is never pulled
  // sampled mid-cycle so registered outputs have settled
  always @(negedge i_ref_clk) begin
    if (o_wr_valid === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= o_wr;
    end
    if (i_reset_n === 1'b1) begin
      chk(o_scl_oe === 1'b0, "clock line pulled");
      chk(o_sda_out === 1'b0, "data driven high");
    end
  end

  // supplies down: no bus answer
  task automatic t_off();
    logic ack;
    chk(o_mode === MODE_OFF && o_i2c_avail === 1'b0 && o_digital_en === 1'b0, "off");
    u_acm_i2c_host.start();
    u_acm_i2c_host.wbyte({DEVA, 1'b0}, 1'b0, ack);
    u_acm_i2c_host.stop();
    chk(ack === 1'b0, "answered while off");
  endtask

  // supplies up, run clear: standby with a working bus
  task automatic t_stby();
    logic [2:0] ak;
    int         w0;
    i_vdd_ok = 1'b1;
    i_vddio_ok = 1'b1;
    tk(5);
    chk(o_mode === MODE_STBY && o_digital_en === 1'b1 && o_i2c_avail === 1'b1, "stby");
    chk(o_analog_en === 1'b0 && o_clk_run === 1'b0, "sensing on in standby");
    w0 = wr_cnt;
    u_acm_i2c_host.start();
    u_acm_i2c_host.wbyte({DEVA, 1'b0}, 1'b0, ak[0]);
    u_acm_i2c_host.wbyte(8'h10, 1'b0, ak[1]);
    u_acm_i2c_host.wbyte(8'h5a, 1'b0, ak[2]);
    u_acm_i2c_host.stop();
    chk(ak === 3'h7, "write not acknowledged");
    chk(wr_cnt == w0 + 1 && wr_last === acm_wr_type'{8'h10, 8'h5a}, "write lost");
  endtask

  // one active period, then back to standby
  task automatic t_act(input logic [1:0] fs, input logic st, input acm_accel_type a,
                       input acm_sample_type e);
    int             n;
    acm_sample_type held;
    i_fs_range = fs;
    i_self_test = st;
    i_accel = a;
    tk(4);
    i_run_en = 1'b1;
    tk(1);
    chk(o_mode === MODE_ACT && o_reg_reset === 1'b1, "no active entry");
    chk(o_sample === '0 && o_data_valid === 1'b0, "sample not cleared");
    chk(o_analog_en === 1'b1 && o_clk_run === 1'b1 && o_i2c_avail === 1'b1, "enables");
    tk(1);
    chk(o_reg_reset === 1'b0, "reset pulse too long");
    n = 1;
    while (o_data_valid !== 1'b1 && n < 3000) begin
      tk(1);
      n++;
    end
    chk(n > TON && n < 3000, "turn-on time");
    chk(o_sample === e, "sample value");
    held = o_sample;
    i_run_en = 1'b0;
    tk(3);
    chk(o_mode === MODE_STBY && o_clk_run === 1'b0 && o_analog_en === 1'b0, "stby");
    i_accel = ~a;
    tk(1200);
    chk(o_sample === held && o_data_valid === 1'b1, "not retained");
  endtask

  // output data read from address 0, address byte spiked
  task automatic t_read();
    logic       ack;
    logic [7:0] d;
    logic [7:0] exp_b [4];
    int         w0;
    exp_b = '{8'h40, 8'h00, 8'hc0, 8'h00};
    w0 = wr_cnt;
    u_acm_i2c_host.start();
    u_acm_i2c_host.wbyte({DEVA, 1'b0}, 1'b1, ack);
    chk(ack === 1'b1, "spiked address lost");
    u_acm_i2c_host.wbyte(DATA_ADDR, 1'b0, ack);
    u_acm_i2c_host.start();
    u_acm_i2c_host.wbyte({DEVA, 1'b1}, 1'b0, ack);
    chk(ack === 1'b1, "read address");
    for (int i = 0; i < 4; i++) begin
      u_acm_i2c_host.rbyte(i == 3, d);
      chk(d === exp_b[i], "data byte");
    end
    u_acm_i2c_host.stop();
    chk(wr_cnt == w0, "pointer taken as data");
  endtask

  // supply loss in active, then return with run still set
  task automatic t_pwr();
    int n;
    i_run_en = 1'b1;
    tk(2);
    i_vdd_ok = 1'b0;
    tk(5);
    chk(o_mode === MODE_OFF && o_i2c_avail === 1'b0 && o_analog_en === 1'b0, "off");
    i_vdd_ok = 1'b1;
    n = 0;
    while (o_mode === MODE_OFF && n < 10) begin
      tk(1);
      n++;
    end
    chk(o_mode === MODE_STBY, "standby skipped");
    tk(1);
    chk(o_mode === MODE_ACT, "no active");
    i_run_en = 1'b0;
  endtask

  // main sequence
  initial begin
    int cpg;
    repeat (12) @(posedge i_ref_clk);
    #1;
    i_reset_n = 1'b1;
    repeat (4) @(posedge i_sense_clk);
    #1;
    i_sense_reset_n = 1'b1;
    tk(10);
    t_off();
    t_stby();
    for (int r = 0; r < 3; r++) begin
      cpg = 256 >> r;
      t_act(2'(r), 1'b0, acm_accel_type'{12'sd256, -12'sd256, 12'sd0},
            acm_sample_type'{10'(cpg), 10'(-cpg), 10'sd0});
      if (r == 0) begin
        t_read();
      end
    end
    t_act(2'h1, 1'b1, acm_accel_type'{12'sd256, -12'sd256, 12'sd0},
          acm_sample_type'{10'sd160, -10'sd96, 10'sd32});
    t_pwr();
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    repeat (90000) @(posedge i_ref_clk);
    miscompares++;
    report_and_stop();
  end
endmodule
